// File: src/dds_control_profiles.sv
// DDS control register file, serial/parallel port, profiles and phase datapath
`include "dds_control_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dds_control_profiles
  import dds_control_pkg::*;
#(
  parameter int SYNC_HALF = `DDS_SYNC_HALF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        io_serial_mode_in,
  input  wire logic [5:0]  par_addr_in,
  input  wire logic [7:0]  par_data_in,
  input  wire logic        par_wr_n_in,
  input  wire logic        par_rd_n_in,
  output logic      [7:0]  par_data_out,
  output logic             par_data_oe_out,
  input  wire logic        ser_clk_in,
  input  wire logic        ser_cs_n_in,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe_out,
  output logic             sdo_out,
  input  wire logic        profile_sel_low_in,
  input  wire logic        profile_sel_high_in,
  input  wire logic        freq_update_strobe_in,
  output logic             sync_out_clock_out,
  output logic             sync_out_clock_oe_out,
  output logic      [13:0] conv_phase_out,
  output logic      [1:0]  active_profile_out,
  output logic             cp_offset_out,
  output logic             cp_polarity_out,
  output logic      [2:0]  ref_div_ratio_out,
  output logic      [2:0]  fb_div_ratio_out,
  output logic             ref_div2_en_out,
  output logic             mixer_pd_out,
  output logic             cp_pd_out,
  output logic             core_pd_out,
  output logic             full_sleep_out
);
  localparam logic [31:0] CFR_RST = `DDS_CFR_RST;
  localparam int          NREG    = int'(`DDS_LAST_ADDR) + 1;

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [22:0] pins;
  logic [22:0] pins_d;

  pin_sync #(.WIDTH(23), .RST_VAL(`DDS_PIN_RST)) u_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .pins_in    ({io_serial_mode_in, freq_update_strobe_in, profile_sel_high_in,
                  profile_sel_low_in, sdio_in, ser_cs_n_in, ser_clk_in,
                  par_rd_n_in, par_wr_n_in, par_data_in, par_addr_in}),
    .pins_out   (pins)
  );

  logic [5:0] s_addr;
  logic [7:0] s_data;
  logic       s_wr_n, s_rd_n, s_sclk, s_cs_n, s_sdi, s_serial, s_fud;
  profile_t   s_psel;

  assign s_addr   = pins[5:0];
  assign s_data   = pins[13:6];
  assign s_wr_n   = pins[14];
  assign s_rd_n   = pins[15];
  assign s_sclk   = pins[16];
  assign s_cs_n   = pins[17];
  assign s_sdi    = pins[18];
  assign s_psel   = {pins[20], pins[19]};
  assign s_fud    = pins[21];
  assign s_serial = pins[22];

  // ------------------------------------------------------------
  // Register bytes and field views
  // ------------------------------------------------------------
  byte_t        regs      [NREG];
  byte_t        next_regs [NREG];
  logic [31:0]  control_function_reg, step_word, prof_ftw [4];
  logic [15:0]  ramp_word;
  logic [13:0]  prof_pow [4];

  assign control_function_reg       = {regs[3], regs[2], regs[1], regs[0]};
  assign step_word = {regs[7], regs[6], regs[5], regs[4]};
  assign ramp_word = {regs[9], regs[8]};

  // Each profile owns a tuning word and a 14-bit offset
  for (genvar p = 0; p < 4; p++) begin : g_prof
    localparam int B = `DDS_PROF_BASE + p * `DDS_PROF_STRIDE;
    localparam int O = B + `DDS_PROF_POW_OFS;
    assign prof_ftw[p] = {regs[B+3], regs[B+2], regs[B+1], regs[B]};
    assign prof_pow[p] = {regs[O+1][5:0], regs[O]};
  end

  function automatic byte_t read_byte(input logic [5:0] a);
    read_byte = (a <= `DDS_LAST_ADDR) ? regs[a] : 8'h00;
  endfunction

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  ser_state_e ser_state, next_ser_state;
  logic [2:0] ser_cnt, next_ser_cnt;
  logic [7:0] ser_sh, next_ser_sh, ser_obyte, next_ser_obyte;
  logic [5:0] ser_addr, next_ser_addr;
  logic       ser_rw, next_ser_rw, ser_obit, next_ser_obit;
  logic       ser_wr;
  logic [7:0] ser_wdata;
  logic       lsb_first, sclk_rise, sclk_fall;

  assign lsb_first = control_function_reg[`CFR_LSB_FIRST];
  assign sclk_rise = s_sclk & ~pins_d[16];
  assign sclk_fall = ~s_sclk & pins_d[16];

  // Instruction byte then data bytes, address stepping per byte
  always_comb begin
    next_ser_state = ser_state;
    next_ser_cnt   = ser_cnt;
    next_ser_sh    = ser_sh;
    next_ser_obyte = ser_obyte;
    next_ser_addr  = ser_addr;
    next_ser_rw    = ser_rw;
    next_ser_obit  = ser_obit;
    ser_wr         = 1'b0;
    ser_wdata      = 8'h00;
    if (!s_serial || s_cs_n) begin
      next_ser_state = SER_INSTR;
      next_ser_cnt   = 3'h0;
    end else if (sclk_rise) begin
      next_ser_sh  = lsb_first ? {s_sdi, ser_sh[7:1]} : {ser_sh[6:0], s_sdi};
      next_ser_cnt = ser_cnt + 3'h1;
      if (ser_cnt == 3'h7) begin
        case (ser_state)
          SER_INSTR: begin
            next_ser_rw    = next_ser_sh[7];
            next_ser_addr  = next_ser_sh[5:0];
            next_ser_obyte = read_byte(next_ser_sh[5:0]);
            next_ser_state = SER_DATA;
          end
          SER_DATA: begin
            ser_wr         = ~ser_rw;
            ser_wdata      = next_ser_sh;
            next_ser_addr  = ser_addr + 6'h01;
            next_ser_obyte = read_byte(ser_addr + 6'h01);
          end
          default: next_ser_state = SER_INSTR;
        endcase
      end
    end else if (sclk_fall && ser_state == SER_DATA) begin
      next_ser_obit = lsb_first ? ser_obyte[ser_cnt] : ser_obyte[3'h7 - ser_cnt];
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ser_state <= SER_INSTR;
      ser_cnt   <= 3'h0;
      ser_sh    <= 8'h00;
      ser_obyte <= 8'h00;
      ser_addr  <= 6'h00;
      ser_rw    <= 1'b0;
      ser_obit  <= 1'b0;
    end else begin
      ser_state <= next_ser_state;
      ser_cnt   <= next_ser_cnt;
      ser_sh    <= next_ser_sh;
      ser_obyte <= next_ser_obyte;
      ser_addr  <= next_ser_addr;
      ser_rw    <= next_ser_rw;
      ser_obit  <= next_ser_obit;
    end
  end

  // ------------------------------------------------------------
  // Register writes from the selected port
  // ------------------------------------------------------------
  logic       par_wr;
  logic       wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;

  assign par_wr  = ~s_serial & s_wr_n & ~pins_d[14];         // End of write pulse
  assign wr_en   = par_wr | ser_wr;
  assign wr_addr = s_serial ? ser_addr : s_addr;
  assign wr_data = s_serial ? ser_wdata : s_data;

  // Unmapped addresses swallow writes
  always_comb begin
    next_regs = regs;
    if (wr_en && wr_addr <= `DDS_LAST_ADDR) begin
      next_regs[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= (i < 4) ? CFR_RST[8*(i%4) +: 8] : 8'h00;
      end
    end else begin
      regs <= next_regs;
    end
  end

  // ------------------------------------------------------------
  // Sync clock, profile select and frequency update
  // ------------------------------------------------------------
  logic [7:0] sync_cnt, next_sync_cnt;
  logic       sync_ph, next_sync_ph, sync_rise;
  profile_t   prof, next_prof;
  logic       load_words;

  // Sync clock keeps running even when the core is powered down
  always_comb begin
    next_sync_cnt = sync_cnt + 8'h01;
    next_sync_ph  = sync_ph;
    if (sync_cnt == 8'(SYNC_HALF - 1)) begin
      next_sync_cnt = 8'h00;
      next_sync_ph  = ~sync_ph;
    end
    sync_rise  = (sync_cnt == 8'(SYNC_HALF - 1)) & ~sync_ph;
    next_prof  = sync_rise ? s_psel : prof;
    load_words = (s_fud & ~pins_d[21]) | (next_prof != prof);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_cnt <= 8'h00;
      sync_ph  <= 1'b0;
      prof     <= 2'h0;
      pins_d   <= `DDS_PIN_RST;
    end else begin
      sync_cnt <= next_sync_cnt;
      sync_ph  <= next_sync_ph;
      prof     <= next_prof;
      pins_d   <= pins;
    end
  end

  // ------------------------------------------------------------
  // Phase datapath
  // ------------------------------------------------------------
  logic [31:0] act_ftw, next_act_ftw, freq_acc, next_freq_acc;
  logic [31:0] phase_acc, next_phase_acc;
  logic [15:0] ramp_cnt, next_ramp_cnt;
  logic [13:0] act_pow, next_act_pow, pow_d, next_pow_d, next_conv;
  logic        sweep_en, core_pd;

  assign sweep_en = control_function_reg[`CFR_SWEEP_EN];
  assign core_pd  = control_function_reg[`CFR_PD_CORE];

  always_comb begin
    next_act_ftw   = load_words ? prof_ftw[next_prof] : act_ftw;
    next_act_pow   = load_words ? prof_pow[next_prof] : act_pow;
    next_freq_acc  = freq_acc;
    next_ramp_cnt  = ramp_cnt;
    next_phase_acc = phase_acc;
    next_pow_d     = pow_d;
    if (!core_pd) begin
      if (!sweep_en) begin
        next_freq_acc = 32'h0;
        next_ramp_cnt = ramp_word;
      end else if (ramp_cnt == 16'h0) begin
        next_ramp_cnt = ramp_word;
        next_freq_acc = freq_acc + step_word;
      end else begin
        next_ramp_cnt = ramp_cnt - 16'h1;
      end
      next_phase_acc = phase_acc + act_ftw + (sweep_en ? freq_acc : 32'h0);
      next_pow_d     = act_pow;
    end
    next_conv = phase_acc[31:18] + pow_d;
    if (control_function_reg[`CFR_SINE_SEL]) begin
      next_conv = next_conv - `DDS_QUARTER_TURN;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_ftw        <= 32'h0;
      act_pow        <= 14'h0;
      freq_acc       <= 32'h0;
      ramp_cnt       <= 16'h0;
      phase_acc      <= 32'h0;
      pow_d          <= 14'h0;
      conv_phase_out <= 14'h0;
    end else begin
      act_ftw        <= next_act_ftw;
      act_pow        <= next_act_pow;
      freq_acc       <= next_freq_acc;
      ramp_cnt       <= next_ramp_cnt;
      phase_acc      <= next_phase_acc;
      pow_d          <= next_pow_d;
      conv_phase_out <= core_pd ? conv_phase_out : next_conv;
    end
  end

  // ------------------------------------------------------------
  // Registered control and port outputs
  // ------------------------------------------------------------
  logic [7:0] next_par_q;
  logic       next_par_oe, next_sdio_oe;
  logic [2:0] next_ref_div, next_fb_div;

  always_comb begin
    next_par_oe  = ~s_serial & ~s_rd_n;
    next_par_q   = next_par_oe ? read_byte(s_addr) : 8'h00;
    next_sdio_oe = s_serial & ~s_cs_n & ser_rw & (ser_state == SER_DATA)
                   & ~control_function_reg[`CFR_SDIO_IN_ONLY];
    next_ref_div = control_function_reg[`CFR_REF_DIV_HI] ? 3'd4 :
                   (control_function_reg[`CFR_REF_DIV_LO] ? 3'd2 : 3'd1);
    next_fb_div  = control_function_reg[`CFR_FB_DIV_HI] ? 3'd4 :
                   (control_function_reg[`CFR_FB_DIV_LO] ? 3'd2 : 3'd1);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      par_data_out          <= 8'h00;
      par_data_oe_out       <= 1'b0;
      sdio_out              <= 1'b0;
      sdio_oe_out           <= 1'b0;
      sdo_out               <= 1'b0;
      sync_out_clock_out    <= 1'b0;
      sync_out_clock_oe_out <= 1'b1;
      active_profile_out    <= 2'h0;
      cp_offset_out         <= 1'b0;
      cp_polarity_out       <= 1'b0;
      ref_div_ratio_out     <= 3'd1;
      fb_div_ratio_out      <= 3'd1;
      ref_div2_en_out       <= 1'b1;
      mixer_pd_out          <= 1'b1;
      cp_pd_out             <= 1'b1;
      core_pd_out           <= 1'b0;
      full_sleep_out        <= 1'b0;
    end else begin
      par_data_out          <= next_par_q;
      par_data_oe_out       <= next_par_oe;
      sdio_out              <= ser_obit;
      sdio_oe_out           <= next_sdio_oe;
      sdo_out               <= ser_obit;
      sync_out_clock_out    <= next_sync_ph & ~control_function_reg[`CFR_SYNC_DISABLE];
      sync_out_clock_oe_out <= ~control_function_reg[`CFR_SYNC_DISABLE];
      active_profile_out    <= prof;
      cp_offset_out         <= control_function_reg[`CFR_CP_OFFSET];
      cp_polarity_out       <= control_function_reg[`CFR_CP_POLARITY];
      ref_div_ratio_out     <= next_ref_div;
      fb_div_ratio_out      <= next_fb_div;
      ref_div2_en_out       <= ~control_function_reg[`CFR_DIV2_DISABLE];
      mixer_pd_out          <= control_function_reg[`CFR_PD_MIXER];
      cp_pd_out             <= control_function_reg[`CFR_PD_CP];
      core_pd_out           <= core_pd;
      full_sleep_out        <= &control_function_reg[`CFR_PD_MIXER:`CFR_PD_CORE];
    end
  end
endmodule
`default_nettype wire

// File: src/dds_control_map.svh
// Register byte map, field positions, reset values and timing counts of the DDS control block
`ifndef DDS_CONTROL_MAP_SVH
`define DDS_CONTROL_MAP_SVH

// ------------------------------------------------------------
// Byte addresses (lowest address holds the least significant byte)
// ------------------------------------------------------------
`define DDS_ADDR_CFR       6'h00
`define DDS_ADDR_STEP      6'h04
`define DDS_ADDR_RAMP      6'h08
`define DDS_PROF_BASE      10
`define DDS_PROF_STRIDE    6
`define DDS_PROF_POW_OFS   4
`define DDS_LAST_ADDR      6'h21

// ------------------------------------------------------------
// Control function register fields
// ------------------------------------------------------------
`define CFR_SWEEP_EN       15
`define CFR_SINE_SEL       14
`define CFR_CP_OFFSET      13
`define CFR_REF_DIV_HI     12
`define CFR_REF_DIV_LO     11
`define CFR_CP_POLARITY    10
`define CFR_FB_DIV_HI      9
`define CFR_FB_DIV_LO      8
`define CFR_DIV2_DISABLE   6
`define CFR_SYNC_DISABLE   5
`define CFR_PD_MIXER       4
`define CFR_PD_CP          3
`define CFR_PD_CORE        2
`define CFR_SDIO_IN_ONLY   1
`define CFR_LSB_FIRST      0

// ------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------
`define DDS_CFR_RST        32'h0000_0018
`define DDS_QUARTER_TURN   14'h1000
`define DDS_SYNC_HALF      2
`define DDS_HOP_MIN_CYCLES 16
`define DDS_PIN_RST        23'h02_C000

`endif

// File: src/dds_control_pkg.sv
// Types shared by the DDS control block
package dds_control_pkg;
  typedef enum logic {SER_INSTR, SER_DATA} ser_state_e;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] profile_t;
endpackage

// File: src/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] pins_out
);
  logic [WIDTH-1:0] meta;

  // ------------------------------------------------------------
  // Per-bit double flop; first stage feeds only the second
  // ------------------------------------------------------------
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        meta[b]     <= RST_VAL[b];
        pins_out[b] <= RST_VAL[b];
      end else begin
        meta[b]     <= pins_in[b];
        pins_out[b] <= meta[b];
      end
    end
  end
endmodule
`default_nettype wire

// File: test/dds_control_profiles_monitor.sv
// Port-level assertion checker for the DDS control block
`timescale 1ns/1ps
`default_nettype none
module dds_control_profiles_monitor #(
  parameter int SYNC_HALF = 2
) (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic [13:0] conv_phase_out,
  input wire logic [1:0]  active_profile_out,
  input wire logic        sync_out_clock_out,
  input wire logic        sync_out_clock_oe_out,
  input wire logic [2:0]  ref_div_ratio_out,
  input wire logic [2:0]  fb_div_ratio_out,
  input wire logic        mixer_pd_out,
  input wire logic        cp_pd_out,
  input wire logic        core_pd_out,
  input wire logic        full_sleep_out
);
  localparam int PER = 2 * SYNC_HALF;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ------------------------------------------------------------
  // Assertions and covers
  // ------------------------------------------------------------
  full_sleep_a: assert property (full_sleep_out == (mixer_pd_out & cp_pd_out & core_pd_out))
    else $error("full sleep flag disagrees with power-down bits");
  ref_ratio_a: assert property (ref_div_ratio_out inside {3'h1, 3'h2, 3'h4})
    else $error("reference divide ratio not 1, 2 or 4");
  fb_ratio_a: assert property (fb_div_ratio_out inside {3'h1, 3'h2, 3'h4})
    else $error("feedback divide ratio not 1, 2 or 4");
  sync_quiet_a: assert property (!sync_out_clock_oe_out |-> !sync_out_clock_out)
    else $error("sync pin not low while disabled");
  sync_period_a: assert property ($rose(sync_out_clock_out) && $past(sync_out_clock_oe_out)
                                  |-> ##PER ($rose(sync_out_clock_out) || !sync_out_clock_oe_out))
    else $error("sync clock period wrong");
  profile_hold_a: assert property ($changed(active_profile_out) |=> $stable(active_profile_out) [*3])
    else $error("profile changed between sync samples");
  core_freeze_a: assert property (core_pd_out [*3] |-> $stable(conv_phase_out))
    else $error("phase moved while core powered down");
  reset_dflt_a: assert property ($rose(arst_n_in) |-> mixer_pd_out && cp_pd_out && !core_pd_out && !full_sleep_out)
    else $error("power-down defaults wrong after reset");
  cover property (full_sleep_out);
  cover property ($changed(active_profile_out));
  cover property (!sync_out_clock_oe_out);
endmodule
`default_nettype wire

// File: test/dds_host_model.sv
// Host controller model driving the I/O port and profile pins
`timescale 1ns/1ps
`default_nettype none
module dds_host_model
  import dds_control_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       par_oe_in,
  input  wire logic       sdio_back_in,
  input  wire logic       sdio_oe_in,
  input  wire logic       sdo_in,
  output logic            mode_out,
  output logic [5:0]      addr_out,
  output logic [7:0]      data_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic            sdio_out,
  output logic            psel_low_out,
  output logic            psel_high_out,
  output logic            upd_out
);
  // ------------------------------------------------------------
  // Idle levels and bus tasks
  // ------------------------------------------------------------
  initial begin
    {mode_out, addr_out, data_out, sclk_out, sdio_out, psel_low_out, psel_high_out, upd_out} = '0;
    {wr_n_out, rd_n_out, cs_n_out} = 3'h7;
  end
  task automatic wr(input logic [5:0] a, input byte_t d);
    @(negedge ref_clk_in);
    addr_out = a;
    data_out = d;
    wr_n_out = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    wr_n_out = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    data_out = ~d; // Released bus shows the inverse
  endtask
  task automatic rd(input logic [5:0] a, output byte_t d);
    @(negedge ref_clk_in);
    addr_out = a;
    rd_n_out = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    d = par_oe_in ? rdata_in : ~rdata_in; // Undriven bus reads as a mismatch
    rd_n_out = 1'b1;
    repeat (5) @(negedge ref_clk_in);
  endtask
  // Serial frame of one byte; read bits taken just before each falling edge
  task automatic ser_io(input logic rw, input logic [5:0] a, input byte_t d, input logic lsb,
                        output byte_t r, output logic [3:0] oe_cnt);
    logic [15:0] w;
    logic        b;
    w = {rw, 1'b0, a, d};
    r = 8'h00;
    oe_cnt = 4'h0;
    @(negedge ref_clk_in);
    mode_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    cs_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdio_out = w[(i < 8 ? 8 : 0) + (lsb ? i % 8 : 7 - i % 8)];
      repeat (3) @(negedge ref_clk_in);
      sclk_out = 1'b1;
      repeat (3) @(negedge ref_clk_in);
      if (i > 7) begin
        b = sdio_oe_in ? sdio_back_in : sdo_in; // 2-wire reads sdio, 3-wire the separate line
        r = lsb ? {b, r[7:1]} : {r[6:0], b};
        oe_cnt = oe_cnt + {3'h0, sdio_oe_in};
      end
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge ref_clk_in);
    cs_n_out = 1'b1;
    sdio_out = ~sdio_out;
    repeat (4) @(negedge ref_clk_in);
    mode_out = 1'b0;
    repeat (4) @(negedge ref_clk_in);
  endtask
  // Binary select, held stable for a full hop interval
  task automatic prof(input profile_t p);
    @(negedge ref_clk_in);
    psel_high_out = p[1];
    psel_low_out = p[0];
    repeat (16) @(negedge ref_clk_in);
  endtask
  task automatic strobe();
    @(negedge ref_clk_in);
    upd_out = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    upd_out = 1'b0;
    repeat (16) @(negedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

// File: test/dds_control_profiles_tb.sv
// Self-checking testbench for the DDS control block
`timescale 1ns/1ps
`default_nettype none
module dds_control_profiles_tb;
  import dds_control_pkg::*;
  typedef struct packed {byte_t b1; byte_t b0; logic [13:0] e;} row_s;
  logic        ref_clk_in, arst_n_in, mode, wr_n, rd_n, sclk, cs_n, sdio, pl, ph, upd;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [13:0] phase, outs;
  logic [1:0]  prof;
  logic        cpo, cpp, d2, mix, cppd, core, sleep, soe, sck;
  logic        poe, sdio_b, sdio_oe, sdo_b;
  logic [2:0]  rr, fr;
  int          n_errors = 0;
  int          samples_checked = 0;
  row_s        rows [4] = '{'{8'h00, 8'h18, 14'h213C}, '{8'h2E, 8'h40, 14'h3A80},
                            '{8'h19, 8'h1C, 14'h245F}, '{8'h13, 8'h24, 14'h0492}};
  logic [13:0] offs [4] = '{14'h0111, 14'h1234, 14'h2ABC, 14'h3FFF};
  assign outs = {soe, cpo, cpp, rr, fr, d2, mix, cppd, core, sleep};
  // ------------------------------------------------------------
  // Design, host and checking tasks
  // ------------------------------------------------------------
  dds_control_profiles uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .io_serial_mode_in(mode),
    .par_addr_in(addr), .par_data_in(wdata), .par_wr_n_in(wr_n), .par_rd_n_in(rd_n), .par_data_out(rdata),
    .par_data_oe_out(poe), .ser_clk_in(sclk), .ser_cs_n_in(cs_n), .sdio_in(sdio), .sdio_out(sdio_b),
    .sdio_oe_out(sdio_oe), .sdo_out(sdo_b), .profile_sel_low_in(pl), .profile_sel_high_in(ph),
    .freq_update_strobe_in(upd),
    .sync_out_clock_out(sck), .sync_out_clock_oe_out(soe), .conv_phase_out(phase), .active_profile_out(prof),
    .cp_offset_out(cpo), .cp_polarity_out(cpp), .ref_div_ratio_out(rr), .fb_div_ratio_out(fr),
    .ref_div2_en_out(d2), .mixer_pd_out(mix), .cp_pd_out(cppd), .core_pd_out(core), .full_sleep_out(sleep));
  dds_host_model host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .par_oe_in(poe), .sdio_back_in(sdio_b),
    .sdio_oe_in(sdio_oe), .sdo_in(sdo_b), .mode_out(mode), .addr_out(addr),
    .data_out(wdata), .wr_n_out(wr_n), .rd_n_out(rd_n), .sclk_out(sclk), .cs_n_out(cs_n), .sdio_out(sdio),
    .psel_low_out(pl), .psel_high_out(ph), .upd_out(upd));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Phase steps over two windows of 8 cycles: first and second difference
  task automatic span(output logic [13:0] d1, output logic [13:0] d2);
    logic [13:0] a, b;
    a = phase;
    repeat (8) @(negedge ref_clk_in);
    b = phase;
    repeat (8) @(negedge ref_clk_in);
    d1 = b - a;
    d2 = phase - b - b + a;
  endtask
  task automatic results();
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // Hang guard
  initial begin
    #100us;
    n_errors++;
    results();
  end
  // Main sequence: reset, control rows, profiles, sine, serial order
  initial begin
    byte_t       rb;
    logic [3:0]  oec;
    logic [13:0] p1, p2;
    arst_n_in = 1'b0;
    repeat (12) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    chk("reset_ctrl", {2'b00, outs}, 16'h213C);
    chk("reset_phase", {2'b00, phase}, 16'h0000);
    host.rd(6'h00, rb);
    chk("reset_cfr0", {8'h00, rb}, 16'h0018);
    host.wr(6'h22, 8'h5A);
    host.rd(6'h22, rb);
    chk("unmapped", {8'h00, rb}, 16'h0000);
    foreach (rows[i]) begin
      host.wr(6'h01, rows[i].b1);
      host.wr(6'h00, rows[i].b0);
      repeat (2) @(negedge ref_clk_in);
      chk("control", {2'b00, outs}, {2'b00, rows[i].e});
      host.rd(6'h01, rb);
      chk("cfr1", {8'h00, rb}, {8'h00, rows[i].b1});
    end
    host.wr(6'h01, 8'h00);
    host.wr(6'h00, 8'h18);
    for (int p = 0; p < 4; p++) begin
      host.wr(6'(14 + 6 * p), offs[p][7:0]);
      host.wr(6'(15 + 6 * p), {2'b00, offs[p][13:8]});
    end
    repeat (4) @(negedge ref_clk_in);
    chk("phase_hold", {2'b00, phase}, 16'h0000);
    host.strobe();
    chk("phase_upd", {2'b00, phase}, {2'b00, offs[0]});
    for (int p = 1; p < 5; p++) begin
      host.prof(profile_t'(p));
      chk("profile", {14'h0000, prof}, {14'h0000, 2'(p)});
      chk("phase_sel", {2'b00, phase}, {2'b00, offs[p % 4]});
    end
    host.wr(6'h01, 8'h40);
    repeat (4) @(negedge ref_clk_in);
    chk("sine", {2'b00, phase}, {2'b00, offs[0] - 14'h1000});
    host.wr(6'h01, 8'h00);
    host.ser_io(1'b0, 6'h00, 8'h19, 1'b0, rb, oec);
    host.ser_io(1'b0, 6'h01, 8'h20, 1'b1, rb, oec);
    repeat (4) @(negedge ref_clk_in);
    chk("ser_lsb", {15'h0000, cpo}, 16'h0001);
    host.rd(6'h00, rb);
    chk("par_order", {8'h00, rb}, 16'h0019);
    chk("par_oe_idle", {15'h0000, poe}, 16'h0000);
    host.ser_io(1'b1, 6'h00, 8'h00, 1'b1, rb, oec);
    chk("ser_rd_2w", {8'h00, rb}, 16'h0019);
    chk("sdio_oe_2w", {12'h000, oec}, 16'h0008);
    host.ser_io(1'b0, 6'h00, 8'h1B, 1'b1, rb, oec);
    host.ser_io(1'b1, 6'h00, 8'h00, 1'b1, rb, oec);
    chk("ser_rd_3w", {8'h00, rb}, 16'h001B);
    chk("sdio_oe_3w", {12'h000, oec}, 16'h0000);
    // Sweep: step of one phase unit per ramp tick gives second difference 64/(ramp+1)
    host.wr(6'h06, 8'h04);
    host.wr(6'h01, 8'h80);
    span(p1, p2);
    chk("sweep_step", {2'b00, p2}, 16'h0040);
    host.wr(6'h08, 8'h03);
    span(p1, p2);
    chk("sweep_ramp", {2'b00, p2}, 16'h0010);
    // Tuning word of three units per cycle waits for the update strobe
    host.wr(6'h01, 8'h00);
    host.wr(6'h0C, 8'h0C);
    span(p1, p2);
    chk("ftw_hold", {2'b00, p1}, 16'h0000);
    host.strobe();
    span(p1, p2);
    chk("ftw_rate", {2'b00, p1}, 16'h0018);
    results();
  end
endmodule
bind dds_control_profiles dds_control_profiles_monitor #(.SYNC_HALF(SYNC_HALF)) mon (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .conv_phase_out(conv_phase_out),
  .active_profile_out(active_profile_out), .sync_out_clock_out(sync_out_clock_out),
  .sync_out_clock_oe_out(sync_out_clock_oe_out), .ref_div_ratio_out(ref_div_ratio_out),
  .fb_div_ratio_out(fb_div_ratio_out), .mixer_pd_out(mixer_pd_out), .cp_pd_out(cp_pd_out),
  .core_pd_out(core_pd_out), .full_sleep_out(full_sleep_out));
`default_nettype wire
